// ===== hw/alu_status_flags.sv
// alu status flag register with result steering and addressing mode decode
`timescale 1ns/1ps
`default_nettype none
module alu_status_flags (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // instruction execution
  input wire logic exec_valid_i,
  input wire asf_pkg::asf_op_t exec_op_i,
  input wire logic [7:0] src_a_i,
  input wire logic [7:0] src_b_i,
  input wire logic dest_is_flags_i,
  // operand addressing
  input wire asf_pkg::asf_ifmt_t instr_fmt_i,
  input wire logic access_bit_i,
  input wire logic [7:0] file_addr_i,
  input wire logic indirect_operand_i,
  input wire logic extended_set_enable_bit_i,
  // results
  output logic [7:0] alu_flags_o,
  output logic [7:0] result_o,
  output logic result_we_o,
  output asf_pkg::asf_amode_t addr_mode_o
);

  // ----------------------------------------------------------------
  // alu calculation
  // ----------------------------------------------------------------
  asf_calc_if cif ();

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] result_r;
  logic [7:0] result_nxt;
  logic we_r;
  logic we_nxt;
  asf_pkg::asf_amode_t amode_r;
  asf_pkg::asf_amode_t amode_nxt;
  logic [4:0] mask;
  logic discard;

  // operands to the calculator, carry taken from the live register
  assign cif.op = exec_op_i;
  assign cif.a = src_a_i;
  assign cif.b = src_b_i;
  assign cif.c_in = flags_r[asf_pkg::FLAG_C];

  asf_alu_calc u_calc (
    .cif(cif)
  );

  // ----------------------------------------------------------------
  // flag register and result steering
  // ----------------------------------------------------------------
  assign mask = asf_pkg::asf_flag_mask(exec_op_i);
  assign discard = dest_is_flags_i && (mask != asf_pkg::MASK_NONE); // RULE2

  // next flags, result and write enable
  always_comb begin
    flags_nxt = flags_r;
    result_nxt = result_r;
    we_nxt = 1'b0;
    if (exec_valid_i) begin
      result_nxt = cif.res;
      we_nxt = !discard; // RULE2
      if (dest_is_flags_i && !discard) begin
        flags_nxt = {asf_pkg::FLAGS_UNUSED, cif.res[4:0]}; // RULE1
      end else begin
        flags_nxt[4:0] = (flags_r[4:0] & ~mask) | (cif.flg & mask); // RULE2 RULE3
      end
    end
    flags_nxt[7:5] = asf_pkg::FLAGS_UNUSED; // RULE11
  end

  // ----------------------------------------------------------------
  // addressing mode decode
  // ----------------------------------------------------------------
  always_comb begin
    amode_nxt = amode_r;
    if (exec_valid_i) begin
      case (instr_fmt_i)
        asf_pkg::FMT_INHERENT: amode_nxt = asf_pkg::AM_INHERENT; // RULE6 RULE7
        asf_pkg::FMT_LITERAL: amode_nxt = asf_pkg::AM_LITERAL; // RULE7
        asf_pkg::FMT_FILE: begin
          if (indirect_operand_i) begin
            amode_nxt = asf_pkg::AM_INDIRECT; // RULE6
          end else if (extended_set_enable_bit_i && !access_bit_i &&
                       file_addr_i <= asf_pkg::ACC_LOW_LAST) begin
            amode_nxt = asf_pkg::AM_INDEXED_LIT; // RULE8 RULE9
          end else begin
            amode_nxt = asf_pkg::AM_DIRECT; // RULE6
          end
        end
        default: amode_nxt = asf_pkg::AM_INHERENT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_r <= asf_pkg::FLAGS_RST;
      result_r <= 8'h00;
      we_r <= 1'b0;
      amode_r <= asf_pkg::AM_INHERENT;
    end else begin
      flags_r <= flags_nxt;
      result_r <= result_nxt;
      we_r <= we_nxt;
      amode_r <= amode_nxt;
    end
  end

  assign alu_flags_o = flags_r;
  assign result_o = result_r;
  assign result_we_o = we_r;
  assign addr_mode_o = amode_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_upper_bits_zero: assert property (alu_flags_o[7:5] == 3'h0) // RULE11
    else $error("flag bits 7 to 5 not zero");

  a_flag_dest_discard: assert property ( // RULE2
    exec_valid_i && dest_is_flags_i && asf_pkg::asf_flag_mask(exec_op_i) != 5'h00
    |=> !result_we_o && alu_flags_o[2] == (result_o == 8'h00))
    else $error("flag destination did not drop the result");

  a_wipe_only_zero: assert property ( // RULE3
    exec_valid_i && dest_is_flags_i && exec_op_i == asf_pkg::OP_WIPE_FILE_INSTR
    |=> alu_flags_o[2] && alu_flags_o[4:3] == $past(alu_flags_o[4:3])
        && alu_flags_o[1:0] == $past(alu_flags_o[1:0]))
    else $error("wipe on flag register changed more than zero flag");

  a_sfr_plain_write: assert property ( // RULE1
    exec_valid_i && dest_is_flags_i && exec_op_i == asf_pkg::OP_PASS_B
    |=> result_we_o && alu_flags_o[4:0] == $past(src_b_i[4:0]))
    else $error("flag register not written as an operand");

  a_sub_borrow: assert property ( // RULE5
    exec_valid_i && !dest_is_flags_i && exec_op_i == asf_pkg::OP_SUB
    |=> alu_flags_o[0] == ($past(src_a_i) >= $past(src_b_i)))
    else $error("subtract borrow polarity wrong");

  a_sign_zero_wrap: assert property ( // RULE10
    exec_valid_i && exec_op_i == asf_pkg::OP_ADD && !dest_is_flags_i
    |=> alu_flags_o[4] == result_o[7] && alu_flags_o[2] == (result_o == 8'h00)
        && alu_flags_o[3] == (($past(src_a_i[7]) == $past(src_b_i[7]))
                              && (result_o[7] != $past(src_a_i[7]))))
    else $error("sign, zero or wrap flag wrong after add");

  a_add_carry: assert property ( // RULE11
    exec_valid_i && exec_op_i == asf_pkg::OP_ADD && !dest_is_flags_i
    |=> alu_flags_o[0] == ((({1'b0, $past(src_a_i)} + {1'b0, $past(src_b_i)}) >> 8) != 9'h000)
        && alu_flags_o[1] == ((($past(src_a_i) & 8'h0F) + ($past(src_b_i) & 8'h0F)) > 8'h0F))
    else $error("carry or nibble carry wrong after add");

  a_rotate_carry: assert property ( // RULE11
    exec_valid_i && !dest_is_flags_i && exec_op_i == asf_pkg::OP_ROTATE_RIGHT_INSTR
    |=> alu_flags_o[0] == $past(src_a_i[0]) && result_o[7] == $past(flags_r[0]))
    else $error("rotate did not pass bit through carry");

  a_indexed_gated: assert property ( // RULE8
    exec_valid_i && !extended_set_enable_bit_i |=> addr_mode_o != asf_pkg::AM_INDEXED_LIT)
    else $error("indexed mode while extended set off");

  a_extended_decode: assert property ( // RULE9
    exec_valid_i && instr_fmt_i == asf_pkg::FMT_FILE && !indirect_operand_i && !access_bit_i
    && file_addr_i <= asf_pkg::ACC_LOW_LAST
    |=> addr_mode_o == ($past(extended_set_enable_bit_i) ? asf_pkg::AM_INDEXED_LIT
                                                          : asf_pkg::AM_DIRECT))
    else $error("extended set bit not honoured in decode");

  a_fixed_modes: assert property ( // RULE6 RULE7
    exec_valid_i && instr_fmt_i == asf_pkg::FMT_LITERAL |=> addr_mode_o == asf_pkg::AM_LITERAL)
    else $error("literal format gave wrong mode");

  a_inherent_fixed: assert property ( // RULE6
    exec_valid_i && instr_fmt_i == asf_pkg::FMT_INHERENT
    |=> addr_mode_o == asf_pkg::AM_INHERENT)
    else $error("inherent format gave wrong mode");

  // strobe and held state between instructions
  a_strobe_single: assert property ( // RULE2
    !exec_valid_i |=> !result_we_o)
    else $error("write strobe stood without an instruction");

  a_idle_hold: assert property ( // RULE1
    !exec_valid_i |=> $stable(alu_flags_o) && $stable(result_o) && $stable(addr_mode_o))
    else $error("state changed without an instruction");

  a_logic_zn_only: assert property ( // RULE10
    exec_valid_i && !dest_is_flags_i
    && exec_op_i inside {asf_pkg::OP_AND, asf_pkg::OP_IOR, asf_pkg::OP_XOR, asf_pkg::OP_MOVF}
    |=> alu_flags_o[4] == result_o[7] && alu_flags_o[2] == (result_o == 8'h00)
        && alu_flags_o[3] == $past(alu_flags_o[3])
        && alu_flags_o[1:0] == $past(alu_flags_o[1:0]))
    else $error("logic operation touched carry, nibble or wrap flag");

  a_neutral_ops_keep: assert property ( // RULE4
    exec_valid_i && !dest_is_flags_i
    && exec_op_i inside {asf_pkg::OP_BIT_CLEAR_INSTR, asf_pkg::OP_BIT_SET_INSTR,
                         asf_pkg::OP_NIBBLE_SWAP_INSTR, asf_pkg::OP_PASS_B}
    |=> alu_flags_o == $past(alu_flags_o))
    else $error("flag-neutral operation changed the flags");

  a_borrow_chain: assert property ( // RULE5
    exec_valid_i && !dest_is_flags_i && exec_op_i == asf_pkg::OP_SUBB
    |=> result_o == $past(src_a_i) - $past(src_b_i) - {7'h00, !$past(alu_flags_o[0])})
    else $error("subtract with borrow ignored the registered borrow");

  c_flag_discard: cover property (exec_valid_i && discard);
  c_wipe_flags: cover property (exec_valid_i && dest_is_flags_i
                                && exec_op_i == asf_pkg::OP_WIPE_FILE_INSTR);
  c_indexed_mode: cover property (addr_mode_o == asf_pkg::AM_INDEXED_LIT);
  c_sub_borrow: cover property (exec_valid_i && exec_op_i == asf_pkg::OP_SUBB && !cif.c_in);
  c_carry_chain: cover property (exec_valid_i && exec_op_i == asf_pkg::OP_ADDC && cif.c_in);

endmodule
`default_nettype wire

// ===== hw/asf_alu_calc.sv
// combinational alu result and raw flag calculation
`timescale 1ns/1ps
`default_nettype none
module asf_alu_calc (
  asf_calc_if.calc cif
);

  logic [7:0] opb;
  logic cin;
  logic [4:0] nib;
  logic [7:0] low7;
  logic [8:0] full;

  // ----------------------------------------------------------------
  // adder operands and result select
  // ----------------------------------------------------------------
  always_comb begin
    opb = cif.b;
    cin = 1'b0;
    case (cif.op)
      asf_pkg::OP_ADDC: cin = cif.c_in;
      asf_pkg::OP_SUB: begin
        opb = ~cif.b; // subtract by adding the complement
        cin = 1'b1;
      end
      asf_pkg::OP_SUBB: begin
        opb = ~cif.b; // carry clear means borrow pending
        cin = cif.c_in;
      end
      default: cin = 1'b0;
    endcase
    nib = {1'b0, cif.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    low7 = {1'b0, cif.a[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
    full = {1'b0, cif.a} + {1'b0, opb} + {8'h00, cin};
    cif.flg = 5'h00;
    case (cif.op)
      asf_pkg::OP_ADD, asf_pkg::OP_ADDC, asf_pkg::OP_SUB, asf_pkg::OP_SUBB: begin
        cif.res = full[7:0];
        cif.flg[asf_pkg::FLAG_C] = full[8]; // RULE5
        cif.flg[asf_pkg::FLAG_DC] = nib[4]; // RULE11
        cif.flg[asf_pkg::FLAG_OV] = low7[7] ^ full[8]; // RULE10
      end
      asf_pkg::OP_AND: cif.res = cif.a & cif.b;
      asf_pkg::OP_IOR: cif.res = cif.a | cif.b;
      asf_pkg::OP_XOR: cif.res = cif.a ^ cif.b;
      asf_pkg::OP_MOVF: cif.res = cif.a;
      asf_pkg::OP_WIPE_FILE_INSTR: cif.res = 8'h00;
      asf_pkg::OP_ROTATE_RIGHT_INSTR: begin
        cif.res = {cif.c_in, cif.a[7:1]};
        cif.flg[asf_pkg::FLAG_C] = cif.a[0]; // RULE11
      end
      asf_pkg::OP_ROTATE_LEFT_INSTR: begin
        cif.res = {cif.a[6:0], cif.c_in};
        cif.flg[asf_pkg::FLAG_C] = cif.a[7]; // RULE11
      end
      asf_pkg::OP_BIT_CLEAR_INSTR: cif.res = cif.a & ~cif.b;
      asf_pkg::OP_BIT_SET_INSTR: cif.res = cif.a | cif.b;
      asf_pkg::OP_NIBBLE_SWAP_INSTR: cif.res = {cif.a[3:0], cif.a[7:4]};
      default: cif.res = cif.b;
    endcase
    cif.flg[asf_pkg::FLAG_N] = cif.res[7]; // RULE10
    cif.flg[asf_pkg::FLAG_Z] = (cif.res == 8'h00); // RULE10
  end

endmodule
`default_nettype wire

// ===== hw/asf_calc_if.sv
// interface between the flag register core and the alu calculation
`timescale 1ns/1ps
`default_nettype none
interface asf_calc_if;
  asf_pkg::asf_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic c_in;
  logic [7:0] res;
  logic [4:0] flg;
  modport core (output op, a, b, c_in, input res, flg);
  modport calc (input op, a, b, c_in, output res, flg);
endinterface
`default_nettype wire

// ===== hw/asf_pkg.sv
// package for the alu status flag register: constants, types and flag masks
// Function
// [RULE1] The arithmetic flags live in one register that any instruction may use as an operand.
// [RULE2] A flag-changing instruction aimed at the flag register drops its result and updates flags.
// [RULE3] Wiping the flag register sets only the zero flag and keeps every other flag bit.
// [RULE4] Software should alter the flags only with bit, swap, move or store instructions.
// [RULE5] In subtraction carry and nibble carry act as borrow flags of inverted polarity.
// [RULE6] Data memory is reached by inherent, literal, direct and indirect addressing.
// [RULE7] Most formats have one fixed mode while file operands choose among up to three.
// [RULE8] Indexed literal offset addressing exists only while the extended set bit is 1.
// [RULE9] The extended set bit changes how some core instructions decode their operand.
// [RULE10] Bit 4 copies the sign, bit 2 flags a zero result, bit 3 flags signed wrap.
// [RULE11] Bit 0 takes the top carry or rotated bit, bit 1 the nibble carry, bits 7 to 5 read 0.
package asf_pkg;

  // ----------------------------------------------------------------
  // flag register layout
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam int FLAG_BITS = 5;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [2:0] FLAGS_UNUSED = 3'h0;
  localparam logic [4:0] MASK_NONE = 5'h00;
  localparam logic [4:0] MASK_ALL = 5'h1F;
  localparam logic [4:0] MASK_ZN = 5'h14;
  localparam logic [4:0] MASK_CZN = 5'h15;
  localparam logic [4:0] MASK_Z = 5'h04;

  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_LOW_LAST = 8'h5F;

  typedef enum logic [3:0] {
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR, OP_MOVF,
    OP_WIPE_FILE_INSTR, OP_ROTATE_RIGHT_INSTR, OP_ROTATE_LEFT_INSTR,
    OP_BIT_CLEAR_INSTR, OP_BIT_SET_INSTR, OP_NIBBLE_SWAP_INSTR, OP_PASS_B
  } asf_op_t;

  typedef enum logic [1:0] {FMT_INHERENT, FMT_LITERAL, FMT_FILE} asf_ifmt_t;

  typedef enum logic [2:0] {
    AM_INHERENT, AM_LITERAL, AM_DIRECT, AM_INDIRECT, AM_INDEXED_LIT
  } asf_amode_t;

  // which flag bits an operation is allowed to change
  function automatic logic [4:0] asf_flag_mask(input asf_op_t op);
    case (op)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: asf_flag_mask = MASK_ALL;
      OP_AND, OP_IOR, OP_XOR, OP_MOVF: asf_flag_mask = MASK_ZN;
      OP_ROTATE_RIGHT_INSTR, OP_ROTATE_LEFT_INSTR: asf_flag_mask = MASK_CZN;
      OP_WIPE_FILE_INSTR: asf_flag_mask = MASK_Z;
      default: asf_flag_mask = MASK_NONE;
    endcase
  endfunction

endpackage

// ===== tb/alu_status_flags_test.sv
// self-checking testbench for the alu status flag register
`timescale 1ns/1ps
`default_nettype none
module alu_status_flags_test;
  // ----------------------------------------------------------------
  // clock, reset and stimulus signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic vld = 1'b0;
  asf_pkg::asf_op_t op = asf_pkg::OP_PASS_B;
  logic [7:0] sa = 8'h00;
  logic [7:0] sb = 8'h00;
  logic dst = 1'b0;
  asf_pkg::asf_ifmt_t fmt = asf_pkg::FMT_FILE;
  logic acc = 1'b1;
  logic [7:0] fa = 8'h00;
  logic ind = 1'b0;
  logic ext = 1'b0;
  logic [7:0] flags;
  logic [7:0] res;
  logic we;
  asf_pkg::asf_amode_t am;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // design under test
  // ----------------------------------------------------------------
  alu_status_flags DUT (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .exec_valid_i(vld),
    .exec_op_i(op),
    .src_a_i(sa),
    .src_b_i(sb),
    .dest_is_flags_i(dst),
    .instr_fmt_i(fmt),
    .access_bit_i(acc),
    .file_addr_i(fa),
    .indirect_operand_i(ind),
    .extended_set_enable_bit_i(ext),
    .alu_flags_o(flags),
    .result_o(res),
    .result_we_o(we),
    .addr_mode_o(am)
  );

  // ----------------------------------------------------------------
  // report and compare tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_mode(input asf_pkg::asf_amode_t got, input asf_pkg::asf_amode_t exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: mode got %0d exp %0d", $time, got, exp);
    end
  endtask

  // one instruction, driven just after an edge; outputs settled on return
  task automatic exec(input asf_pkg::asf_op_t o, input logic [7:0] a, input logic [7:0] b,
                      input logic d);
    @(posedge clk_i);
    #1;
    vld = 1'b1;
    op = o;
    sa = a;
    sb = b;
    dst = d;
    @(posedge clk_i);
    #1;
    vld = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // signed wrap on add, then the write strobe drops after one cycle
  task automatic t_add();
    exec(asf_pkg::OP_ADD, 8'h7F, 8'h01, 1'b0);
    chk8(res, 8'h80, "add result");
    chk8(flags, 8'h1A, "add flags");
    chk8({7'h00, we}, 8'h01, "add strobe");
    chk_mode(am, asf_pkg::AM_DIRECT);
    @(posedge clk_i);
    #1;
    chk8({7'h00, we}, 8'h00, "strobe low");
  endtask

  // borrow polarity of carry and nibble carry
  task automatic t_sub();
    exec(asf_pkg::OP_SUB, 8'h05, 8'h06, 1'b0);
    chk8(flags, 8'h10, "sub borrow");
    chk8(res, 8'hFF, "sub result");
    exec(asf_pkg::OP_SUB, 8'h10, 8'h01, 1'b0);
    chk8(flags, 8'h01, "sub nibble borrow");
    exec(asf_pkg::OP_SUB, 8'h33, 8'h33, 1'b0);
    chk8(flags, 8'h07, "sub equal");
  endtask

  // flag register as destination, wipe, bit and rotate operations
  task automatic t_dest();
    exec(asf_pkg::OP_ADD, 8'hFF, 8'h01, 1'b1);
    chk8(flags, 8'h07, "add to flags");
    chk8({7'h00, we}, 8'h00, "add to flags strobe");
    exec(asf_pkg::OP_PASS_B, 8'h00, 8'h1B, 1'b1);
    chk8(flags, 8'h1B, "store to flags");
    exec(asf_pkg::OP_WIPE_FILE_INSTR, flags, 8'h00, 1'b1);
    chk8(flags, 8'h1F, "wipe flags");
    chk8({7'h00, we}, 8'h00, "wipe strobe");
    exec(asf_pkg::OP_BIT_SET_INSTR, 8'h00, 8'h80, 1'b0);
    chk8(flags, 8'h1F, "bit set keeps");
    exec(asf_pkg::OP_ROTATE_LEFT_INSTR, 8'h80, 8'h00, 1'b0);
    chk8(res, 8'h01, "rotate left");
    chk8(flags, 8'h0B, "rotate left flags");
    exec(asf_pkg::OP_ROTATE_RIGHT_INSTR, 8'h01, 8'h00, 1'b0);
    chk8(res, 8'h80, "rotate right");
    chk8(flags, 8'h1B, "rotate right flags");
  endtask

  // one addressing case with a flag-neutral operation
  task automatic mode_case(input asf_pkg::asf_ifmt_t f, input logic a, input logic [7:0] ad,
                           input logic i, input logic x, input asf_pkg::asf_amode_t exp);
    fmt = f;
    acc = a;
    fa = ad;
    ind = i;
    ext = x;
    exec(asf_pkg::OP_PASS_B, 8'h00, 8'h00, 1'b0);
    chk_mode(am, exp);
  endtask

  task automatic t_modes();
    mode_case(asf_pkg::FMT_INHERENT, 1'b1, 8'h00, 1'b0, 1'b1, asf_pkg::AM_INHERENT);
    mode_case(asf_pkg::FMT_LITERAL, 1'b0, 8'h00, 1'b0, 1'b1, asf_pkg::AM_LITERAL);
    mode_case(asf_pkg::FMT_FILE, 1'b0, 8'h10, 1'b1, 1'b1, asf_pkg::AM_INDIRECT);
    mode_case(asf_pkg::FMT_FILE, 1'b0, 8'h5F, 1'b0, 1'b1, asf_pkg::AM_INDEXED_LIT);
    mode_case(asf_pkg::FMT_FILE, 1'b0, 8'h60, 1'b0, 1'b1, asf_pkg::AM_DIRECT);
    mode_case(asf_pkg::FMT_FILE, 1'b0, 8'h10, 1'b0, 1'b0, asf_pkg::AM_DIRECT);
  endtask

  // carry chains, logic flags and flag-neutral operations
  task automatic t_logic();
    exec(asf_pkg::OP_PASS_B, 8'h00, 8'h00, 1'b1);
    chk8(flags, 8'h00, "clear flags");
    exec(asf_pkg::OP_SUBB, 8'h10, 8'h01, 1'b0);
    chk8(res, 8'h0E, "sub with borrow");
    chk8(flags, 8'h01, "sub with borrow flags");
    exec(asf_pkg::OP_ADDC, 8'hFF, 8'h00, 1'b0);
    chk8(res, 8'h00, "add with carry");
    chk8(flags, 8'h07, "add with carry flags");
    exec(asf_pkg::OP_XOR, 8'hF0, 8'h0F, 1'b0);
    chk8(flags, 8'h13, "xor flags");
    exec(asf_pkg::OP_IOR, 8'h00, 8'h00, 1'b0);
    chk8(flags, 8'h07, "ior flags");
    exec(asf_pkg::OP_AND, 8'hC3, 8'h81, 1'b0);
    chk8(res, 8'h81, "and result");
    chk8(flags, 8'h13, "and flags");
    exec(asf_pkg::OP_MOVF, 8'h00, 8'hFF, 1'b0);
    chk8(flags, 8'h07, "move flags");
    exec(asf_pkg::OP_BIT_CLEAR_INSTR, 8'hFF, 8'h10, 1'b0);
    chk8(res, 8'hEF, "bit clear");
    exec(asf_pkg::OP_NIBBLE_SWAP_INSTR, 8'hA5, 8'h00, 1'b0);
    chk8(res, 8'h5A, "nibble swap");
    chk8(flags, 8'h07, "neutral ops keep");
    exec(asf_pkg::OP_BIT_CLEAR_INSTR, flags, 8'h04, 1'b1);
    chk8(flags, 8'h03, "bit clear on flags");
    chk8({7'h00, we}, 8'h01, "bit clear strobe");
  endtask

  // mid-run reset returns flags, result and mode to their reset values
  task automatic t_reset();
    rst_b_i = 1'b0;
    #1;
    chk8(flags, 8'h00, "mid reset flags");
    chk8(res, 8'h00, "mid reset result");
    chk_mode(am, asf_pkg::AM_INHERENT);
    @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    exec(asf_pkg::OP_PASS_B, 8'h00, 8'h5A, 1'b0);
    chk8(res, 8'h5A, "first after reset");
    chk8({7'h00, we}, 8'h01, "first strobe");
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    chk8(flags, 8'h00, "reset flags");
    chk8({7'h00, we}, 8'h00, "reset strobe");
    chk_mode(am, asf_pkg::AM_INHERENT);
    rst_b_i = 1'b1;
    t_add();
    t_sub();
    t_dest();
    t_modes();
    t_logic();
    t_reset();
    print_verdict();
  end

  // cut a hang short well past the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      print_verdict();
    end
  end
endmodule
`default_nettype wire
